/* include/mise_pkg.sv */
// constants for the instruction subset execution block
// assumes a wishbone master with 32-bit data and byte address
package mise_pkg;
    // -------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] OPND_OFF = 8'h04;
    localparam logic [7:0] ACC_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0c;
    localparam logic [7:0] T0MODE_OFF = 8'h10;
    localparam logic [7:0] TBLPTR_OFF = 8'h14;
    localparam logic [7:0] TBLDAT_OFF = 8'h18;
    localparam logic [7:0] REG_OFF = 8'h1c;
    localparam logic [7:0] CTRL_OFF = 8'h20;
    // -------------------------------------------------------------
    // status fields
    // -------------------------------------------------------------
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_BUSY = 5;
    localparam logic [7:0] STAT_RST = 8'h18;
    // -------------------------------------------------------------
    // commands
    // -------------------------------------------------------------
    localparam logic [3:0] OP_HALT = 4'h1;
    localparam logic [3:0] OP_SUBI = 4'h2;
    localparam logic [3:0] OP_SWAP = 4'h3;
    localparam logic [3:0] OP_LDT0 = 4'h4;
    localparam logic [3:0] OP_RDT0 = 4'h5;
    localparam logic [3:0] OP_TBL = 4'h6;
    localparam logic [3:0] OP_XORR = 4'h7;
    localparam logic [3:0] OP_XORI = 4'h8;
    localparam int CMD_DEST_BIT = 4;
    localparam int TBL_CYCLES = 2;
    localparam int ROM_AW = 11;
    localparam int ROM_DW = 14;
endpackage : mise_pkg

/* rtl/mise_alu.sv */
// combinational datapath of the instruction subset
// assumes operands stable from registers of the same clock
`timescale 1ns/100ps
module mise_alu (
    input wire logic [3:0] op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] reg_i,
    input wire logic [7:0] t0_i,
    output logic [7:0] res_o,
    output logic upd_zdc_c_o,
    output logic upd_z_o,
    output logic z_o,
    output logic dc_o,
    output logic c_o
);
    // -------------------------------------------------------------
    // arithmetic
    // -------------------------------------------------------------
    wire logic [8:0] diff = {1'b0, imm_i} + {1'b0, ~acc_i} + 9'h001;
    wire logic [4:0] ldiff = {1'b0, imm_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
    wire logic [7:0] xsrc = (op_i == mise_pkg::OP_XORR) ? reg_i : imm_i;
    wire logic [7:0] xres = acc_i ^ xsrc;
    wire logic [7:0] swp = {reg_i[3:0], reg_i[7:4]};
    always_comb begin
        res_o = acc_i;
        case (op_i)
            mise_pkg::OP_SUBI: res_o = diff[7:0];
            mise_pkg::OP_SWAP: res_o = swp;
            mise_pkg::OP_RDT0: res_o = t0_i;
            mise_pkg::OP_XORR: res_o = xres;
            mise_pkg::OP_XORI: res_o = xres;
            default: res_o = acc_i;
        endcase
    end
    assign upd_zdc_c_o = (op_i == mise_pkg::OP_SUBI);
    assign upd_z_o = (op_i == mise_pkg::OP_XORR) || (op_i == mise_pkg::OP_XORI);
    assign z_o = (res_o == 8'h00);
    assign dc_o = ldiff[4];
    assign c_o = diff[8];
endmodule : mise_alu

/* rtl/mise_core.sv */
// execution of an 8-bit mcu instruction subset behind wishbone
// assumes program rom answers while rom_en_o stands
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module mise_core #(
    parameter int ROM_AW = mise_pkg::ROM_AW,
    parameter int ROM_DW = mise_pkg::ROM_DW
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [ROM_AW-1:0] rom_addr_o,
    output logic rom_en_o,
    input wire logic [ROM_DW-1:0] rom_data_i,
    output logic wdt_clear_o,
    output logic prescaler_clear_o,
    output logic halt_req_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o
);
    typedef enum logic [1:0] {MISE_IDLE, MISE_TBL} mise_state_t;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // zero-extend a byte onto the read bus
    function automatic logic [31:0] word_of(input logic [7:0] v);
        return {24'h00_0000, v};
    endfunction : word_of
    // address match for one register offset
    function automatic logic hit_at(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction : hit_at
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    mise_state_t st_q;
    logic [7:0] acc_q;
    logic [7:0] imm_q;
    logic [7:0] reg_q;
    logic [7:0] t0_q;
    logic [2:0] tptr_q;
    logic [5:0] tdat_q;
    logic [4:0] flags_q;
    logic [4:0] cmd_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [ROM_AW-1:0] raddr_q;
    logic ren_q;
    logic wdt_q;
    logic halt_q;
    logic rwr_q;
    logic [7:0] rwd_q;
    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wr = req && wb_we_i && wb_sel_i[0];
    wire logic wr_cmd = wr && hit_at(wb_adr_i, mise_pkg::CMD_OFF);
    wire logic wr_opnd = wr && hit_at(wb_adr_i, mise_pkg::OPND_OFF);
    wire logic wr_acc = wr && hit_at(wb_adr_i, mise_pkg::ACC_OFF);
    wire logic wr_t0 = wr && hit_at(wb_adr_i, mise_pkg::T0MODE_OFF);
    wire logic wr_tptr = wr && hit_at(wb_adr_i, mise_pkg::TBLPTR_OFF);
    wire logic wr_reg = wr && hit_at(wb_adr_i, mise_pkg::REG_OFF);
    wire logic busy = (st_q == MISE_TBL);
    wire logic start = wr_cmd && !busy;
    wire logic [3:0] op = wb_dat_i[3:0];
    wire logic dest = wb_dat_i[mise_pkg::CMD_DEST_BIT];
    wire logic [7:0] stat = {2'b00, busy, flags_q};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            mise_pkg::CMD_OFF: rd_mux = word_of({3'h0, cmd_q});
            mise_pkg::OPND_OFF: rd_mux = word_of(imm_q);
            mise_pkg::ACC_OFF: rd_mux = word_of(acc_q);
            mise_pkg::STAT_OFF: rd_mux = word_of(stat);
            mise_pkg::T0MODE_OFF: rd_mux = word_of(t0_q);
            mise_pkg::TBLPTR_OFF: rd_mux = word_of({5'h00, tptr_q});
            mise_pkg::TBLDAT_OFF: rd_mux = word_of({2'h0, tdat_q});
            mise_pkg::REG_OFF: rd_mux = word_of(reg_q);
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // -------------------------------------------------------------
    // datapath
    // -------------------------------------------------------------
    logic [7:0] res;
    logic upd3;
    logic updz;
    logic fz;
    logic fdc;
    logic fc;
    mise_alu u_alu (
        .op_i(op),
        .acc_i(acc_q),
        .imm_i(imm_q),
        .reg_i(reg_q),
        .t0_i(t0_q),
        .res_o(res),
        .upd_zdc_c_o(upd3),
        .upd_z_o(updz),
        .z_o(fz),
        .dc_o(fdc),
        .c_o(fc)
    );
    wire logic is_reg_op = (op == mise_pkg::OP_SWAP) || (op == mise_pkg::OP_XORR);
    wire logic to_reg = start && is_reg_op && dest;
    wire logic to_acc = start && !(is_reg_op && dest) &&
        ((op == mise_pkg::OP_SUBI) || is_reg_op || (op == mise_pkg::OP_RDT0) ||
         (op == mise_pkg::OP_XORI));
    wire logic halt_op = start && (op == mise_pkg::OP_HALT);
    wire logic tbl_op = start && (op == mise_pkg::OP_TBL);
    wire logic tbl_done = (st_q == MISE_TBL);

    // -------------------------------------------------------------
    // next values
    // -------------------------------------------------------------
    wire logic ldt0_op = start && (op == mise_pkg::OP_LDT0);
    wire logic acc_we = tbl_done || to_acc || wr_acc;
    wire logic t0_we = wr_t0 || ldt0_op;
    wire logic reg_we = wr_reg || to_reg;
    // rom word wins: no command is taken while busy
    wire logic [7:0] acc_d = tbl_done ? rom_data_i[7:0] :
        to_acc ? res : wb_dat_i[7:0];
    wire logic [5:0] tdat_d = rom_data_i[13:8];
    wire logic [7:0] reg_d = to_reg ? res : wb_dat_i[7:0];
    wire logic [7:0] t0_d = ldt0_op ? acc_q : wb_dat_i[7:0];
    wire logic [ROM_AW-1:0] raddr_d = ROM_AW'({tptr_q, acc_q});
    logic [4:0] flags_d;
    mise_state_t st_d;

    // -------------------------------------------------------------
    // status flags
    // -------------------------------------------------------------
    always_comb begin
        flags_d = flags_q;
        if (start && upd3) begin
            flags_d[mise_pkg::ST_C] = fc;
            flags_d[mise_pkg::ST_DC] = fdc;
            flags_d[mise_pkg::ST_Z] = fz;
        end else if (start && updz) begin
            flags_d[mise_pkg::ST_Z] = fz;
        end
        // halt touches only timeout and powerdown
        if (halt_op) begin
            flags_d[mise_pkg::ST_TO] = 1'b1;
            flags_d[mise_pkg::ST_PD] = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    // one extra cycle for the rom word
    always_comb begin
        st_d = st_q;
        case (st_q)
            MISE_IDLE: st_d = tbl_op ? MISE_TBL : MISE_IDLE;
            MISE_TBL: st_d = MISE_IDLE;
            default: st_d = MISE_IDLE;
        endcase
    end

    // -------------------------------------------------------------
    // bus answer
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            rdat_q <= rd_mux;
        end
    end

    // -------------------------------------------------------------
    // output pulses
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_q <= 1'b0;
            halt_q <= 1'b0;
            rwr_q <= 1'b0;
            rwd_q <= 8'h00;
            ren_q <= 1'b0;
        end else begin
            wdt_q <= halt_op;
            halt_q <= halt_op;
            rwr_q <= to_reg;
            rwd_q <= res;
            ren_q <= tbl_op;
        end
    end

    // -------------------------------------------------------------
    // rom address
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raddr_q <= '0;
        end else if (tbl_op) begin
            raddr_q <= raddr_d;
        end
    end

    // -------------------------------------------------------------
    // command and operands
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= 5'h00;
            imm_q <= 8'h00;
            tptr_q <= 3'h0;
        end else begin
            if (start) begin
                cmd_q <= wb_dat_i[4:0];
            end
            if (wr_opnd) begin
                imm_q <= wb_dat_i[7:0];
            end
            if (wr_tptr) begin
                tptr_q <= wb_dat_i[2:0];
            end
        end
    end

    // -------------------------------------------------------------
    // register operand and timer0 mode
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_q <= 8'h00;
            t0_q <= 8'h00;
        end else begin
            if (reg_we) begin
                reg_q <= reg_d;
            end
            if (t0_we) begin
                t0_q <= t0_d;
            end
        end
    end

    // -------------------------------------------------------------
    // accumulator and table data
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= 8'h00;
            tdat_q <= 6'h00;
        end else begin
            if (acc_we) begin
                acc_q <= acc_d;
            end
            if (tbl_done) begin
                tdat_q <= tdat_d;
            end
        end
    end

    // -------------------------------------------------------------
    // status and state
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= mise_pkg::STAT_RST[4:0];
            st_q <= MISE_IDLE;
        end else begin
            flags_q <= flags_d;
            st_q <= st_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign rom_addr_o = raddr_q;
    assign rom_en_o = ren_q;
    assign wdt_clear_o = wdt_q;
    assign prescaler_clear_o = wdt_q;
    assign halt_req_o = halt_q;
    assign reg_wr_o = rwr_q;
    assign reg_wdata_o = rwd_q;
endmodule : mise_core

/* verif/mise_rom_model.sv */
// program rom stand-in answering within the strobe cycle
// assumes rom_en_i pulses once per read
`timescale 1ns/100ps
module mise_rom_model (
    input wire logic clk_i,
    input wire logic rom_en_i,
    input wire logic [10:0] rom_addr_i,
    output logic [13:0] rom_data_o
);
    // word while the strobe stands, inverse otherwise
    wire logic [13:0] word = {rom_addr_i[10:5] ^ 6'h15, rom_addr_i[7:0] ^ 8'h5a};
    always_comb begin
        rom_data_o = rom_en_i ? word : ~word;
    end
endmodule : mise_rom_model

/* verif/mise_core_monitor.sv */
// port assertions for mise_core
// assumes one clock and synchronous active-high reset
`timescale 1ns/100ps
module mise_core_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rom_en_o,
    input wire logic wdt_clear_o,
    input wire logic prescaler_clear_o,
    input wire logic halt_req_o,
    input wire logic reg_wr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire cmd = take && wb_we_i && wb_sel_i[0] && wb_adr_i == mise_pkg::CMD_OFF;
    wire [3:0] op = wb_dat_i[3:0];
    wire halt_cmd = cmd && op == mise_pkg::OP_HALT;
    wire tbl_cmd = cmd && op == mise_pkg::OP_TBL;
    wire dst_cmd = cmd && wb_dat_i[4];
    wire dst_op = op == mise_pkg::OP_SWAP || op == mise_pkg::OP_XORR;
    wire any_halt = halt_req_o || wdt_clear_o || prescaler_clear_o;
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    ack_timing_a: assert property (take |=> s_pulse(wb_ack_o))
        else $error("ack not one cycle after request");
    halt_pulse_a: assert property (halt_cmd |=>
        (wdt_clear_o && prescaler_clear_o) ##0 s_pulse(halt_req_o))
        else $error("halt pulses missing");
    halt_cause_a: assert property (any_halt |-> $past(halt_cmd))
        else $error("halt pulse without halt command");
    tbl_rom_a: assert property (tbl_cmd |=> s_pulse(rom_en_o))
        else $error("table read did not strobe rom");
    rom_cause_a: assert property (rom_en_o |-> $past(tbl_cmd))
        else $error("rom strobe without table read");
    regwr_cause_a: assert property (reg_wr_o |-> $past(dst_cmd))
        else $error("register write with destination bit low");
    regwr_dest_a: assert property (dst_cmd && dst_op |=> s_pulse(reg_wr_o))
        else $error("register write missing");
    xori_noreg_a: assert property (cmd && op == mise_pkg::OP_XORI |=> !reg_wr_o)
        else $error("immediate xor wrote register");
    unmapped_rd_a: assert property (take && !wb_we_i && wb_adr_i == mise_pkg::CTRL_OFF
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule : mise_core_monitor
bind mise_core mise_core_monitor i_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rom_en_o(rom_en_o),
    .wdt_clear_o(wdt_clear_o),
    .prescaler_clear_o(prescaler_clear_o),
    .halt_req_o(halt_req_o),
    .reg_wr_o(reg_wr_o)
);

/* verif/mise_core_test.sv */
// self-checking bench for mise_core with a rom stand-in
// assumes wishbone answer one cycle after a request is taken
`timescale 1ns/100ps
module mise_core_test;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, rom_en, wr_o, hit = 0;
    logic [7:0] adr = 8'h00, wv, got;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [10:0] rom_addr;
    logic hq, wq, pq;
    logic [2:0] hlt = 3'h0;
    logic [13:0] rom_data;
    bit c, dc, z, to = 1, pd = 1;
    int fails = 0, n_checks = 0, seed = 32'h2306;
    int a, i, r, t, p, op, d, res, hd = 0, w;
    mise_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rom_addr_o(rom_addr), .rom_en_o(rom_en), .rom_data_i(rom_data),
        .wdt_clear_o(wq), .prescaler_clear_o(pq), .halt_req_o(hq), .reg_wr_o(wr_o),
        .reg_wdata_o(wv));
    mise_rom_model i_rom (.clk_i(clk_i), .rom_en_i(rom_en), .rom_addr_i(rom_addr),
        .rom_data_o(rom_data));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (wr_o === 1'b1) begin
        hit <= 1;
        got <= wv;
    end
    always @(posedge clk_i) if ((hq | wq | pq) === 1'b1) begin
        hlt <= {hq, wq, pq};
    end
    task close_out;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task bus(input logic wr, input logic [7:0] ad, input logic [31:0] dv);
        int k;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= wr;
        adr <= ad;
        wdat <= dv;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 9);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
        if (ack !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask : bus
    task rd(input logic [7:0] ad, input logic [31:0] e);
        bus(0, ad, 0);
        chk(rdat, e);
    endtask : rd
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        rd(mise_pkg::STAT_OFF, 32'h18);
        bus(1, mise_pkg::CTRL_OFF, 32'h5a);
        for (int n = 0; n < 200; n++) begin
            op = n < 16 ? n % 8 + 1 : ($random(seed) & 7) + 1;
            a = $random(seed) & 255;
            i = n % 5 == 0 ? a : $random(seed) & 255;
            r = $random(seed) & 255;
            t = $random(seed) & 255;
            p = $random(seed) & 7;
            d = n < 8 ? 0 : n < 16 ? 1 : $random(seed) & 1;
            bus(1, mise_pkg::ACC_OFF, a);
            bus(1, mise_pkg::OPND_OFF, i);
            bus(1, mise_pkg::REG_OFF, r);
            bus(1, mise_pkg::T0MODE_OFF, t);
            bus(1, mise_pkg::TBLPTR_OFF, p);
            hit = 0;
            hlt = 3'h0;
            bus(1, mise_pkg::CMD_OFF, d * 16 + op);
            @(posedge clk_i);
            res = a;
            case (op)
                1: {to, pd} = 2'b10;
                2: begin
                    res = (i - a) & 255;
                    {c, dc, z} = {i >= a, (i & 15) >= (a & 15), res == 0};
                    a = res;
                end
                3: res = (r % 16) * 16 + r / 16;
                4: t = a;
                5: a = t;
                6: begin
                    w = p * 256 + a;
                    hd = ((w >> 5) & 63) ^ 21;
                    a = (w & 255) ^ 90;
                end
                7: res = a ^ r;
                8: a = a ^ i;
                default: res = a;
            endcase
            if (op == 7 || op == 8) z = (op == 7 ? res : a) == 0;
            chk({hit, hit ? got : 8'h0}, (op == 3 || op == 7) && d ? 256 + res : 0);
            chk(hlt, op == 1 ? 7 : 0);
            if ((op == 3 || op == 7) && !d) a = res;
            rd(mise_pkg::ACC_OFF, a);
            rd(mise_pkg::STAT_OFF, {to, pd, z, dc, c});
            rd(mise_pkg::T0MODE_OFF, t);
            rd(mise_pkg::TBLDAT_OFF, hd);
        end
        rd(mise_pkg::CTRL_OFF, 0);
        close_out();
    end
endmodule : mise_core_test
